//--- in_endpoint.sv
`timescale 1ns/1ns
`include "usb_ep_regs.svh"
module in_endpoint (
	input  wire logic              clk,        // Clock.
	input  wire logic              rst_n,      // Asynchronous reset, active low.
	input  wire logic              wr_low,     // Write to control low.
	input  wire logic              wr_high,    // Write to control high.
	input  wire logic [7:0]        wdata,      // Write data.
	input  wire logic              token,      // IN token for this endpoint.
	input  wire logic              ack,        // Host ACK for this endpoint.
	input  wire logic              sof,        // Start of frame.
	input  wire logic              iso_update, // Hold new packets to next frame.
	output logic [7:0]             csr_low,    // Control low readback.
	output logic [7:0]             csr_high,   // Control high readback.
	output usb_ep_pkg::resp_t      resp,       // Answer to the current token.
	output logic                   toggle,     // Data toggle.
	output logic                   irq         // Endpoint event pulse.
);
	import usb_ep_pkg::*;

	logic       send_stall, sent_stall, underrun, force_tog, iso, dbl;
	logic       ready, hold, wait_ack, load, sent;
	logic [1:0] cnt, cap, next_cnt;

	// Pick the answer to an IN token.
	always_comb begin
		if (!token)
			resp = RESP_NONE;
		else if (send_stall)
			resp = RESP_STALL;                        // [RULE10]
		else if (cnt != 2'd0 && !hold)
			resp = RESP_DATA;                         // [RULE21]
		else if (iso)
			resp = RESP_ZLP;                          // [RULE18] [RULE20]
		else
			resp = RESP_NONE;
	end

	assign cap      = dbl ? `CAP_DOUBLE : `CAP_SINGLE;
	assign load     = wr_low && wdata[`EL_IRDY] && !ready;
	assign sent     = (resp == RESP_DATA);
	assign next_cnt = 2'(cnt + {1'b0, load} - {1'b0, sent});
	assign irq      = (resp == RESP_STALL) || sent; // [RULE11] [RULE15]

	// Packet slot count; ready reads one only while no slot is free.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt   <= 2'd0;
			ready <= 1'b0;
		end else begin
			cnt   <= next_cnt;
			ready <= (next_cnt >= cap);               // [RULE13] [RULE14]
		end
	end

	// Packets loaded in iso mode under iso update wait for the next start of frame.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hold <= 1'b0;
		else if (load && iso && iso_update)
			hold <= 1'b1;                             // [RULE21]
		else if (sof)
			hold <= 1'b0;
	end

	// Stall request and sticky status flags; hardware set wins.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			send_stall <= 1'b0;
			sent_stall <= 1'b0;
			underrun   <= 1'b0;
		end else begin
			if (wr_low)
				send_stall <= wdata[`EL_SDSTALL];
			sent_stall <= (resp == RESP_STALL) ||
				(sent_stall && !(wr_low && !wdata[`EL_STSTALL])); // [RULE11] [RULE12]
			underrun   <= (resp == RESP_ZLP) ||
				(underrun && !(wr_low && !wdata[`EL_UNDERRUN]));  // [RULE20]
		end
	end

	// Data toggle: forced alternation or advance on host ACK.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			toggle   <= 1'b0;
			wait_ack <= 1'b0;
		end else begin
			if (wr_low && wdata[`EL_CLRTOG])
				toggle <= 1'b0;
			else if (sent && force_tog)
				toggle <= !toggle;                    // [RULE16]
			else if (ack && wait_ack && !force_tog)
				toggle <= !toggle;                    // [RULE17]
			if (sent)
				wait_ack <= !iso;
			else if (ack || token)
				wait_ack <= 1'b0;
		end
	end

	// Mode bits.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			force_tog <= 1'b0;
			iso       <= 1'b0;
			dbl       <= 1'b0;
		end else if (wr_high) begin
			force_tog <= wdata[`EH_FTOG];
			iso       <= wdata[`EH_ISO];                // [RULE18]
			dbl       <= wdata[`EH_DBL];
		end
	end

	// Readback of the control bytes; unused bits and the clear-toggle strobe read zero.
	always_comb begin
		csr_low                = `RST_BYTE;
		csr_low[`EL_STSTALL]   = sent_stall;
		csr_low[`EL_SDSTALL]   = send_stall;
		csr_low[`EL_UNDERRUN]  = underrun;
		csr_low[`EL_NOTEMPTY]  = (cnt != 2'd0);
		csr_low[`EL_IRDY]      = ready;
		csr_high               = `RST_BYTE;
		csr_high[`EH_DBL]      = dbl;
		csr_high[`EH_ISO]      = iso;
		csr_high[`EH_FTOG]     = force_tog;
	end
endmodule

//--- testbench.sv
`timescale 1ns/1ns
`include "usb_ep_regs.svh"
module testbench;
	import usb_ep_pkg::*;
	logic        CLK, RST_N, ADDR_WE, DATA_WE, DATA_RE, GLOBAL_INT_EN, USB_IRQ;
	logic        SOF_STB, IN_TOKEN, HOST_ACK, SETUP_RX, OUT_RX0, CTRL_END;
	logic        TX_VALID, TX_TOGGLE;
	logic [7:0]  WDATA, RDATA;
	logic [10:0] FRAME_NUM;
	logic [1:0]  TOKEN_EP, TX_EP;
	resp_t       TX_KIND;
	int          bad_count = 0;
	int          check_count = 0;
	usb_endpoint_control #(.NUM_IN_EP(3)) DUT (.CLK(CLK), .RST_N(RST_N), .ADDR_WE(ADDR_WE),
		.DATA_WE(DATA_WE), .DATA_RE(DATA_RE), .WDATA(WDATA), .RDATA(RDATA),
		.GLOBAL_INT_EN(GLOBAL_INT_EN), .USB_IRQ(USB_IRQ), .SOF_STB(SOF_STB),
		.FRAME_NUM(FRAME_NUM), .IN_TOKEN(IN_TOKEN), .TOKEN_EP(TOKEN_EP), .HOST_ACK(HOST_ACK),
		.SETUP_RX(SETUP_RX), .OUT_RX0(OUT_RX0), .CTRL_END(CTRL_END), .TX_VALID(TX_VALID),
		.TX_KIND(TX_KIND), .TX_EP(TX_EP), .TX_TOGGLE(TX_TOGGLE));
	usb_host host (.clk(CLK), .in_token(IN_TOKEN), .ep(TOKEN_EP), .ack(HOST_ACK), .sof(SOF_STB),
		.frame(FRAME_NUM), .setup(SETUP_RX), .out0(OUT_RX0), .ctrl_end(CTRL_END));
	// Free-running clock at 100 MHz.
	always #5 CLK = ~CLK;
	// Compares one value and counts the outcome.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// One register bus strobe, held across exactly one sampling edge.
	task automatic bus(input logic a, input logic w, input logic r, input logic [7:0] d);
		@(posedge CLK);
		#1;
		{ADDR_WE, DATA_WE, DATA_RE, WDATA} = {a, w, r, d};
		@(posedge CLK);
		#1;
		{ADDR_WE, DATA_WE, DATA_RE, WDATA} = {3'b000, ~d};
	endtask
	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		bus(1'b1, 1'b0, 1'b0, adr);
		bus(1'b0, 1'b1, 1'b0, d);
	endtask
	task automatic rchk(input logic [7:0] adr, input logic [7:0] m, input logic [7:0] exp);
		bus(1'b1, 1'b0, 1'b0, adr);
		bus(1'b0, 1'b0, 1'b1, 8'h00);
		chk(RDATA & m, exp);
	endtask
	// Sends an IN token and judges the answer in the one cycle that it stands.
	task automatic tok(input logic [1:0] e, input logic v, input resp_t k);
		host.send(0, e, 11'h000);
		if (v)
			chk({3'b000, TX_VALID, TX_KIND, TX_EP}, {3'b000, v, k, e});
		else
			chk({7'h00, TX_VALID}, 8'h00);
	endtask
	task automatic t_frame();
		host.send(2, 2'd0, 11'h5_A3);
		rchk(`ADR_FRAME_LOW, 8'hFF, 8'hA3);
		rchk(`ADR_FRAME_HIGH, 8'h07, 8'h05);
		host.send(2, 2'd0, 11'h1_3C);
		wr(`ADR_FRAME_LOW, 8'h00);
		rchk(`ADR_FRAME_LOW, 8'hFF, 8'h3C);
		rchk(`ADR_CSR_LOW, 8'hFF, 8'h00);
		rchk(`ADR_IN_IE, 8'hFF, 8'h0F);
		wr(8'h30, 8'h55);
		rchk(8'h30, 8'hFF, 8'h00);
	endtask
	task automatic t_stall();
		wr(`ADR_INDEX, 8'h01);
		wr(`ADR_CSR_LOW, 8'h10);
		tok(2'd1, 1'b1, RESP_STALL);
		@(posedge CLK);
		#1;
		chk({7'h00, USB_IRQ}, 8'h01);
		tok(2'd1, 1'b1, RESP_STALL);
		rchk(`ADR_CSR_LOW, 8'h30, 8'h30);
		rchk(`ADR_IN_INT, 8'hFF, 8'h02);
		@(posedge CLK);
		#1;
		chk({7'h00, USB_IRQ}, 8'h00);
		rchk(`ADR_IN_INT, 8'hFF, 8'h00);
		wr(`ADR_CSR_LOW, 8'h00); // Firmware clears the sent flag itself.
		rchk(`ADR_CSR_LOW, 8'h30, 8'h00);
		tok(2'd1, 1'b0, RESP_NONE);
		wr(`ADR_IN_IE, 8'h0D);
		wr(`ADR_CSR_LOW, 8'h10);
		tok(2'd1, 1'b1, RESP_STALL);
		@(posedge CLK);
		#1;
		chk({7'h00, USB_IRQ}, 8'h00);
		wr(`ADR_IN_IE, 8'h0F);
		GLOBAL_INT_EN = 1'b0;
		@(posedge CLK);
		#1;
		chk({7'h00, USB_IRQ}, 8'h00);
		GLOBAL_INT_EN = 1'b1;
		@(posedge CLK);
		#1;
		chk({7'h00, USB_IRQ}, 8'h01);
		rchk(`ADR_IN_INT, 8'hFF, 8'h02);
		wr(`ADR_CSR_LOW, 8'h00);
	endtask
	task automatic t_toggle();
		wr(`ADR_INDEX, 8'h02);
		wr(`ADR_CSR_LOW, 8'h01);
		rchk(`ADR_CSR_LOW, 8'h01, 8'h01);
		tok(2'd2, 1'b1, RESP_DATA);
		chk({7'h00, TX_TOGGLE}, 8'h00);
		rchk(`ADR_CSR_LOW, 8'h01, 8'h00);
		host.send(1, 2'd2, 11'h000);
		wr(`ADR_CSR_LOW, 8'h01);
		tok(2'd2, 1'b1, RESP_DATA);
		chk({7'h00, TX_TOGGLE}, 8'h01);
		rchk(`ADR_IN_INT, 8'hFF, 8'h04);
		wr(`ADR_CSR_LOW, 8'h01);
		tok(2'd2, 1'b1, RESP_DATA);
		chk({7'h00, TX_TOGGLE}, 8'h01);
		rchk(`ADR_IN_INT, 8'hFF, 8'h04);
	endtask
	task automatic t_force();
		wr(`ADR_INDEX, 8'h03);
		wr(`ADR_CSR_HIGH, 8'h08);
		for (int i = 0; i < 3; i++) begin
			wr(`ADR_CSR_LOW, 8'h01);
			tok(2'd3, 1'b1, RESP_DATA);
			chk({7'h00, TX_TOGGLE}, {7'h00, i[0]});
			host.send(1, 2'd3, 11'h000);
		end
		wr(`ADR_CSR_LOW, 8'h41);
		tok(2'd3, 1'b1, RESP_DATA);
		chk({7'h00, TX_TOGGLE}, 8'h00);
		rchk(`ADR_IN_INT, 8'hFF, 8'h08);
	endtask
	task automatic t_double();
		wr(`ADR_INDEX, 8'h02);
		wr(`ADR_CSR_HIGH, 8'h80);
		wr(`ADR_CSR_LOW, 8'h01);
		rchk(`ADR_CSR_LOW, 8'h03, 8'h02);
		rchk(`ADR_IN_INT, 8'hFF, 8'h00);
		wr(`ADR_CSR_LOW, 8'h01);
		tok(2'd2, 1'b1, RESP_DATA);
		tok(2'd2, 1'b1, RESP_DATA);
		tok(2'd2, 1'b0, RESP_NONE);
		rchk(`ADR_IN_INT, 8'hFF, 8'h04);
	endtask
	task automatic t_iso();
		wr(`ADR_INDEX, 8'h03);
		wr(`ADR_CSR_HIGH, 8'hC0); // Iso with double buffering.
		tok(2'd3, 1'b1, RESP_ZLP);
		rchk(`ADR_CSR_LOW, 8'h04, 8'h04);
		rchk(`ADR_IN_INT, 8'hFF, 8'h00);
		wr(`ADR_POWER, 8'h80);
		wr(`ADR_CSR_LOW, 8'h01);
		tok(2'd3, 1'b1, RESP_ZLP);
		host.send(2, 2'd0, 11'h1_40);
		tok(2'd3, 1'b1, RESP_DATA);
		wr(`ADR_POWER, 8'h00);
		wr(`ADR_CSR_HIGH, 8'h00);
	endtask
	task automatic t_ep0();
		wr(`ADR_INDEX, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(`ADR_CSR_LOW, 8'h02);
			rchk(`ADR_CSR_LOW, 8'h02, 8'h02);
			if (i == 0)
				tok(2'd0, 1'b1, RESP_DATA);
			else
				host.send(2 + i, 2'd0, 11'h000);
			rchk(`ADR_CSR_LOW, 8'h02, 8'h00);
			rchk(`ADR_IN_INT, 8'h01, 8'h01);
		end
		rchk(`ADR_CSR_LOW, 8'h41, 8'h01);
		wr(`ADR_CSR_LOW, 8'h40);
		rchk(`ADR_CSR_LOW, 8'h41, 8'h00);
		wr(`ADR_CSR_LOW, 8'h20);
		tok(2'd0, 1'b1, RESP_STALL);
		rchk(`ADR_CSR_LOW, 8'h24, 8'h04);
		wr(`ADR_CSR_LOW, 8'h00);
		rchk(`ADR_IN_INT, 8'hFF, 8'h01);
		host.send(5, 2'd0, 11'h000);
		rchk(`ADR_CSR_LOW, 8'h10, 8'h10);
		rchk(`ADR_IN_INT, 8'h01, 8'h01);
		wr(`ADR_CSR_LOW, 8'h80);
		rchk(`ADR_CSR_LOW, 8'h90, 8'h00);
		wr(`ADR_CSR_LOW, 8'h0A);
		rchk(`ADR_CSR_LOW, 8'h08, 8'h08);
		tok(2'd0, 1'b1, RESP_DATA);
		host.send(5, 2'd0, 11'h000);
		rchk(`ADR_CSR_LOW, 8'h18, 8'h00);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Cuts a hang short well beyond the expected few hundred cycles.
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
	// Reset for six cycles, then the scenarios in turn.
	initial begin
		{CLK, RST_N, ADDR_WE, DATA_WE, DATA_RE, GLOBAL_INT_EN, WDATA} = '0;
		repeat (6) @(posedge CLK);
		#1;
		RST_N = 1'b1;
		GLOBAL_INT_EN = 1'b1;
		t_frame();
		t_stall();
		t_toggle();
		t_force();
		t_double();
		t_iso();
		t_ep0();
		complete_run();
	end
endmodule

//--- usb_endpoint_control.sv
`timescale 1ns/1ns
`include "usb_ep_regs.svh"
// Notes on behaviour
// RULE1: Frame number low register holds low byte of last received frame number.
// RULE2: Interrupt request rises when any enabled interrupt flag is set.
// RULE3: Reading an interrupt flag register clears all its flags; software cannot write them.
// RULE4: A global enable from the processor gates the interrupt request.
// RULE5: Setup end sets if control transaction ends without data end; serviced write clears it.
// RULE6: Serviced output ready write clears output ready; it reads back zero.
// RULE7: Endpoint zero send stall answers with STALL, then clears itself.
// RULE8: Data end is set by software and cleared by hardware afterwards.
// RULE9: Endpoint zero input ready clears with interrupt on send or overwrite.
// RULE10: IN endpoint with send stall set answers every IN token with STALL.
// RULE11: Each STALL sent sets the sent stall flag and raises an interrupt.
// RULE12: Firmware clears sent stall itself; hardware never clears it.
// RULE13: Input ready resets once a packet slot is free.
// RULE14: Double buffered endpoint clears input ready right after first load, no interrupt.
// RULE15: IN data interrupt only when a data packet is sent.
// RULE16: Force toggle alternates data toggle on every sent IN packet.
// RULE17: Without force toggle, toggle advances only on host ACK.
// RULE18: Isochronous select bit puts the endpoint in isochronous mode.
// RULE19: Firmware should enable double buffering on isochronous IN endpoints.
// RULE20: Isochronous token with empty FIFO sends zero length packet, sets underrun.
// RULE21: With iso update, new packets wait for the next start of frame.
// RULE22: Registers are reached through an address register and a data register.
// RULE23: Endpoint registers are selected by writing the endpoint number to an index.
module usb_endpoint_control #(
	parameter int NUM_IN_EP = 3
) (
	input  wire logic              CLK,           // System clock.
	input  wire logic              RST_N,         // Asynchronous reset, active low.
	input  wire logic              ADDR_WE,       // Write indirect address register.
	input  wire logic              DATA_WE,       // Write indirect data register.
	input  wire logic              DATA_RE,       // Read indirect data register.
	input  wire logic [7:0]        WDATA,         // Write data.
	output logic [7:0]             RDATA,         // Read data, valid after read.
	input  wire logic              GLOBAL_INT_EN, // Global interrupt enable bit.
	output logic                   USB_IRQ,       // Interrupt request.
	input  wire logic              SOF_STB,       // Start of frame received.
	input  wire logic [10:0]       FRAME_NUM,     // Frame number with SOF_STB.
	input  wire logic              IN_TOKEN,      // IN token received.
	input  wire logic [1:0]        TOKEN_EP,      // Endpoint of token or ACK.
	input  wire logic              HOST_ACK,      // ACK received from host.
	input  wire logic              SETUP_RX,      // SETUP packet on endpoint zero.
	input  wire logic              OUT_RX0,       // OUT data on endpoint zero.
	input  wire logic              CTRL_END,      // Control transaction ended.
	output logic                   TX_VALID,      // Answer pulse.
	output usb_ep_pkg::resp_t      TX_KIND,       // Answer kind.
	output logic [1:0]             TX_EP,         // Answer endpoint.
	output logic                   TX_TOGGLE      // Data toggle of the answer.
);
	import usb_ep_pkg::*;

	logic [7:0]                   addr, index, in_ie;
	logic [`FRAME_W-1:0]          frame;
	logic                         iso_update;
	logic [NUM_IN_EP:0]           in_flags, flag_set;
	logic                         e0_oready, e0_stall, e0_setup_end, e0_dend;
	logic                         e0_sent_stall, e0_iready;
	logic                         wr0, tx0, stall0, data0, rd_flags;
	logic [7:0]                   e0_csr, rd_mux;
	logic [NUM_IN_EP:1][7:0]      ep_low, ep_high;
	logic [NUM_IN_EP:1]           ep_tog, ep_irq;
	resp_t                        ep_resp [1:NUM_IN_EP];
	resp_t                        next_kind;
	logic                         next_tog;

	// Address and index selection for indirect access.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			addr  <= `RST_BYTE;
			index <= `RST_BYTE;
		end else begin
			if (ADDR_WE)
				addr <= WDATA;                                  // [RULE22]
			if (DATA_WE && addr == `ADR_INDEX)
				index <= WDATA;                                 // [RULE23]
		end
	end

	// Interrupt enables and the iso update control.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			in_ie      <= `RST_IN_IE;
			iso_update <= 1'b0;
		end else if (DATA_WE) begin
			if (addr == `ADR_IN_IE)
				in_ie <= WDATA;
			if (addr == `ADR_POWER)
				iso_update <= WDATA[`PW_ISOUPD];
		end
	end

	// Frame number capture on each start of frame.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			frame <= '0;
		else if (SOF_STB)
			frame <= FRAME_NUM;                                 // [RULE1]
	end

	// Endpoint zero strobes: control write, IN token, and the stall or data answer.
	assign wr0    = DATA_WE && addr == `ADR_CSR_LOW && index == `RST_BYTE;
	assign tx0    = IN_TOKEN && TOKEN_EP == 2'd0;
	assign stall0 = tx0 && e0_stall;
	assign data0  = tx0 && !e0_stall && e0_iready;

	// Endpoint zero handshake bits; hardware set wins over software clear.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			e0_oready <= 1'b0;
			e0_stall  <= 1'b0;
			e0_setup_end  <= 1'b0;
			e0_dend       <= 1'b0;
			e0_sent_stall <= 1'b0;
			e0_iready <= 1'b0;
		end else begin
			e0_oready <= SETUP_RX || OUT_RX0 ||
				(e0_oready && !(wr0 && WDATA[`E0_SVC_OREADY]));   // [RULE6]
			e0_stall  <= wr0 ? WDATA[`E0_SDSTALL] : (e0_stall && !stall0); // [RULE7]
			e0_setup_end <= (CTRL_END && !e0_dend) ||
				(e0_setup_end && !(wr0 && WDATA[`E0_SVC_SETUP])); // [RULE5]
			if (wr0 && WDATA[`E0_DEND])
				e0_dend <= 1'b1;
			else if (CTRL_END)
				e0_dend <= 1'b0;                                // [RULE8]
			e0_sent_stall <= stall0 ||
				(e0_sent_stall && !(wr0 && !WDATA[`E0_STSTALL])); // [RULE7]
			e0_iready <= (wr0 && WDATA[`E0_IRDY]) ||
				(e0_iready && !(data0 || SETUP_RX || OUT_RX0));   // [RULE9]
		end
	end

	// Endpoint zero status byte; the serviced bits always read zero.
	always_comb begin
		e0_csr              = `RST_BYTE;
		e0_csr[`E0_SDSTALL] = e0_stall;
		e0_csr[`E0_SETUP_END] = e0_setup_end;
		e0_csr[`E0_DEND]    = e0_dend;
		e0_csr[`E0_STSTALL] = e0_sent_stall;
		e0_csr[`E0_IRDY]    = e0_iready;
		e0_csr[`E0_ORDY]    = e0_oready;
	end

	// One IN endpoint instance per endpoint number above zero.
	for (genvar k = 1; k <= NUM_IN_EP; k++) begin : g_ep
		in_endpoint u_ep (
			.clk        (CLK),
			.rst_n      (RST_N),
			.wr_low     (DATA_WE && addr == `ADR_CSR_LOW && index == 8'(k)),
			.wr_high    (DATA_WE && addr == `ADR_CSR_HIGH && index == 8'(k)),
			.wdata      (WDATA),
			.token      (IN_TOKEN && TOKEN_EP == 2'(k)),
			.ack        (HOST_ACK && TOKEN_EP == 2'(k)),
			.sof        (SOF_STB),
			.iso_update (iso_update),
			.csr_low    (ep_low[k]),
			.csr_high   (ep_high[k]),
			.resp       (ep_resp[k]),
			.toggle     (ep_tog[k]),
			.irq        (ep_irq[k])
		);
	end

	// Interrupt sources per endpoint.
	assign flag_set = {ep_irq, stall0 || data0 || SETUP_RX || OUT_RX0 ||
		(CTRL_END && !e0_dend)};                                 // [RULE9]
	assign rd_flags = DATA_RE && addr == `ADR_IN_INT;

	// Sticky flags cleared by reading; a new event in the same cycle survives.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			in_flags <= '0;
		else
			in_flags <= (rd_flags ? '0 : in_flags) | flag_set;   // [RULE3]
	end

	// Enabled flags gated by the global enable.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			USB_IRQ <= 1'b0;
		else
			USB_IRQ <= GLOBAL_INT_EN &&
				|(in_flags & in_ie[NUM_IN_EP:0]);                 // [RULE2] [RULE4]
	end

	// Read multiplexer for the data register.
	always_comb begin
		rd_mux = `RST_BYTE;
		case (addr)
			`ADR_FRAME_LOW:  rd_mux = frame[7:0];
			`ADR_FRAME_HIGH: rd_mux = 8'(frame[`FRAME_W-1:8]);
			`ADR_INDEX:      rd_mux = index;
			`ADR_IN_INT:     rd_mux = 8'(in_flags);
			`ADR_IN_IE:      rd_mux = in_ie;
			`ADR_POWER:      rd_mux = {iso_update, 7'd0};
			`ADR_CSR_LOW: begin
				if (index == `RST_BYTE)
					rd_mux = e0_csr;
				for (int i = 1; i <= NUM_IN_EP; i++)
					if (index == 8'(i))
						rd_mux = ep_low[i];
			end
			`ADR_CSR_HIGH: begin
				for (int i = 1; i <= NUM_IN_EP; i++)
					if (index == 8'(i))
						rd_mux = ep_high[i];
			end
			default:         rd_mux = `RST_BYTE;
		endcase
	end

	// Read data is captured on the read strobe and holds until the next read.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			RDATA <= `RST_BYTE;
		else if (DATA_RE)
			RDATA <= rd_mux;
	end

	// Select the answer of the addressed endpoint.
	always_comb begin
		next_kind = RESP_NONE;
		next_tog  = 1'b0;
		if (tx0)
			next_kind = stall0 ? RESP_STALL : (data0 ? RESP_DATA : RESP_NONE);
		for (int i = 1; i <= NUM_IN_EP; i++)
			if (TOKEN_EP == 2'(i)) begin
				next_kind = ep_resp[i];
				next_tog  = ep_tog[i];
			end
	end

	// Registered answer to the host; a missing pulse means the token is refused.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			TX_VALID  <= 1'b0;
			TX_KIND   <= RESP_NONE;
			TX_EP     <= 2'd0;
			TX_TOGGLE <= 1'b0;
		end else begin
			TX_VALID  <= IN_TOKEN && next_kind != RESP_NONE;
			TX_KIND   <= next_kind;
			TX_EP     <= TOKEN_EP;
			TX_TOGGLE <= next_tog;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	frame_capture_a: assert property (SOF_STB |=> frame[7:0] == $past(FRAME_NUM[7:0])) // [RULE1]
		else $error("frame low not captured");
	irq_raise_a: assert property (GLOBAL_INT_EN && !DATA_WE && |(flag_set & in_ie[NUM_IN_EP:0])
		##1 GLOBAL_INT_EN |=> USB_IRQ) // [RULE2]
		else $error("irq not raised");
	irq_gate_a: assert property (!GLOBAL_INT_EN |=> !USB_IRQ) // [RULE4]
		else $error("irq not gated");
	flag_clear_a: assert property (rd_flags && flag_set == '0 |=> in_flags == '0) // [RULE3]
		else $error("flags not cleared by read");
	setup_end_a: assert property (CTRL_END && !e0_dend |=> e0_setup_end ##0 in_flags[0]) // [RULE5]
		else $error("setup end not flagged");
	oready_clear_a: assert property (wr0 && WDATA[`E0_SVC_OREADY] && !SETUP_RX && !OUT_RX0
		|=> !e0_oready) // [RULE6]
		else $error("output ready not cleared");
	stall_zero_a: assert property (stall0 && !wr0
		|=> !e0_stall && TX_VALID && TX_KIND == RESP_STALL && e0_sent_stall) // [RULE7]
		else $error("ep0 stall not handled");
	data_end_a: assert property (CTRL_END && !(wr0 && WDATA[`E0_DEND]) |=> !e0_dend) // [RULE8]
		else $error("data end not cleared");
	iready_clear_a: assert property ((data0 || SETUP_RX || OUT_RX0) && !wr0
		|=> !e0_iready && in_flags[0]) // [RULE9]
		else $error("ep0 input ready not cleared");
	ep_stall_a: assert property (IN_TOKEN && TOKEN_EP != 2'd0 && next_kind == RESP_STALL
		|=> TX_VALID && TX_KIND == RESP_STALL && in_flags[TX_EP]) // [RULE10] [RULE11]
		else $error("in endpoint stall not answered");

	stall_sent_c: cover property (TX_VALID && TX_KIND == RESP_STALL);
	data_sent_c:  cover property (TX_VALID && TX_KIND == RESP_DATA && TX_EP != 2'd0);
	zlp_sent_c:   cover property (TX_VALID && TX_KIND == RESP_ZLP);
	read_clr_c:   cover property (rd_flags && in_flags != '0);
endmodule

//--- usb_ep_pkg.sv
package usb_ep_pkg;
	// Answer given to an IN token, Gray coded.
	typedef enum logic [1:0] {
		RESP_NONE  = 2'b00,
		RESP_DATA  = 2'b01,
		RESP_ZLP   = 2'b11,
		RESP_STALL = 2'b10
	} resp_t;
endpackage

//--- usb_ep_regs.svh
`ifndef USB_EP_REGS_SVH
`define USB_EP_REGS_SVH
// Indirect register addresses.
`define ADR_POWER      8'h01
`define ADR_IN_INT     8'h02
`define ADR_IN_IE      8'h07
`define ADR_FRAME_LOW  8'h0C
`define ADR_FRAME_HIGH 8'h0D
`define ADR_INDEX      8'h0E
`define ADR_CSR_LOW    8'h11
`define ADR_CSR_HIGH   8'h12
// Reset values.
`define RST_BYTE       8'h00
`define RST_IN_IE      8'h0F
// Endpoint zero control and status fields.
`define E0_SVC_SETUP   7
`define E0_SVC_OREADY  6
`define E0_SDSTALL     5
`define E0_SETUP_END   4
`define E0_DEND        3
`define E0_STSTALL     2
`define E0_IRDY        1
`define E0_ORDY        0
// IN endpoint control low fields.
`define EL_CLRTOG      6
`define EL_STSTALL     5
`define EL_SDSTALL     4
`define EL_UNDERRUN    2
`define EL_NOTEMPTY    1
`define EL_IRDY        0
// IN endpoint control high fields.
`define EH_DBL         7
`define EH_ISO         6
`define EH_FTOG        3
// Power register field.
`define PW_ISOUPD      7
// Frame number width and slot capacities.
`define FRAME_W        11
`define CAP_SINGLE     2'd1
`define CAP_DOUBLE     2'd2
`endif

//--- usb_host.sv
`timescale 1ns/1ns
// Host side of the bus: each call drives one pulse of one kind for one cycle.
module usb_host (
	input  wire logic        clk,      // Clock.
	output logic             in_token, // IN token pulse.
	output logic [1:0]       ep,       // Endpoint of token or ACK.
	output logic             ack,      // ACK pulse.
	output logic             sof,      // Start of frame pulse.
	output logic [10:0]      frame,    // Frame number with the frame start.
	output logic             setup,    // SETUP packet on endpoint zero.
	output logic             out0,     // OUT data on endpoint zero.
	output logic             ctrl_end  // Control transaction end.
);
	// All pulses idle at time zero.
	initial begin
		{in_token, ack, sof, setup, out0, ctrl_end} = '0;
		ep = 2'b10;
		frame = 11'h2_AA;
	end
	// Qualifiers are inverted when idle so that a stale value never helps.
	task automatic send(input int kind, input logic [1:0] e, input logic [10:0] f);
		@(posedge clk);
		#1;
		ep = e;
		frame = f;
		case (kind)
			0: in_token = 1'b1; // One IN token per frame on iso pipes.
			1: ack = 1'b1;      // Handshake after a data packet.
			2: sof = 1'b1;      // Frame start releases held packets.
			3: setup = 1'b1;
			4: out0 = 1'b1;
			default: ctrl_end = 1'b1;
		endcase
		@(posedge clk);
		#1;
		{in_token, ack, sof, setup, out0, ctrl_end} = '0;
		ep = ~ep;
		frame = ~frame;
	endtask
endmodule
